// File: core/timer_zero_pkg.sv
package timer_zero_pkg;

  localparam int          COUNT_W          = 8;
  localparam int          SEL_W            = 3;
  localparam int          PRESCALE_W       = 8;
  localparam logic [7:0]  COUNT_RESET      = 8'h00;
  localparam logic [7:0]  COUNT_MAX        = 8'hFF;
  localparam logic [7:0]  PRESCALE_RESET   = 8'h00;
  localparam logic [2:0]  SELECT_RESET     = 3'h7;
  localparam logic        BYPASS_RESET     = 1'b1;
  localparam logic        SOURCE_RESET     = 1'b1;
  localparam logic [1:0]  PHASE_RESET      = 2'h0;
  localparam logic [1:0]  PHASE_Q2         = 2'h1;
  localparam logic [1:0]  PHASE_Q4         = 2'h3;
  localparam int          CLOCK_HZ         = 20000000;
  localparam int          PHASES_PER_CYCLE = 4;

  typedef struct packed {
    logic       external_source;
    logic       falling_edge;
    logic       prescaler_bypass;
    logic [2:0] prescale_select;
  } option_cfg_s;

  typedef struct packed {
    logic       overflow_flag;
    logic       overflow_irq_enable;
  } interrupt_control_s;

endpackage : timer_zero_pkg

// File: core/timer_zero_prescaler.sv
`timescale 1ns/100ps
`default_nettype none

module timer_zero_prescaler
  import timer_zero_pkg::*;
#(
  parameter int WIDTH = PRESCALE_W
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             tick,
  input  wire logic             clear,
  input  wire logic [SEL_W-1:0] select,
  output logic                  divided
);

  logic [WIDTH-1:0] count_r;

  // Private counter, no software path in or out
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_r <= WIDTH'(PRESCALE_RESET);
    end else if (clear) begin
      count_r <= WIDTH'(PRESCALE_RESET);
    end else if (tick) begin
      count_r <= count_r + WIDTH'(1);
    end
  end

  // Bit n of the counter toggles every 2^n ticks, so it rises once every 2^(n+1)
  assign divided = count_r[select];

endmodule : timer_zero_prescaler

`default_nettype wire

// File: core/timer_zero_prescaled_counter.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Counts pass through the prescaler only while the bypass bit is clear.
// - Eight prescale ratios, divide-by-2 to divide-by-256, via three-bit select.
// - Bypass bit set gives an undivided one-to-one count rate.
// - Prescaler count has no software read or write path.
// - Any write of the count register clears the prescaler.
// - Rollover FFh to 00h requests an interrupt when enable is set.
// - Every rollover sets the overflow flag regardless of the enable.
// - Hardware never clears the overflow flag; only a software write does.
// - Overflow interrupt is no wake-up source from sleep.
// - External count edges pass two clock flops first; Q2/Q4 sampling comes only after the prescaler.
// - Synchronisation samples the prescaler output on phases two and four.
// - Counting stops in sleep and the count holds its value.
// - This prescaler is separate from the watchdog's own prescaler.
module timer_zero_prescaled_counter
  import timer_zero_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               sleep,
  input  wire logic               external_count_input,
  input  wire option_cfg_s        option_cfg,
  input  wire logic               count_write,
  input  wire logic [COUNT_W-1:0] count_wdata,
  input  wire logic               control_write,
  input  wire interrupt_control_s control_wdata,
  output logic [COUNT_W-1:0]      timer_count,
  output interrupt_control_s      interrupt_control_reg,
  output logic                    overflow_irq,
  output logic                    wake_request
);

  logic [1:0]         phase_r;
  logic               cycle_tick;
  logic               pin_meta_r;
  logic               pin_sync_r;
  logic               pin_last_r;
  logic               pin_edge;
  logic               source_tick;
  logic               presc_out;
  logic               presc_s2_r;
  logic               presc_s4_r;
  logic               presc_rise;
  logic               count_inc;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic               rollover;
  logic               flag_r;
  logic               enable_r;
  logic               irq_r;

  // Instruction cycle is four clock phases; enable pulse once per cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      phase_r <= PHASE_RESET;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign cycle_tick = (phase_r == PHASE_Q4);

  // Pin comes from outside; two flops before any logic sees it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_last_r <= 1'b0;
    end else begin
      pin_meta_r <= external_count_input;
      pin_sync_r <= pin_meta_r;
      pin_last_r <= pin_sync_r;
    end
  end

  // Edge polarity selectable; rising by default
  assign pin_edge = option_cfg.falling_edge ? (pin_last_r & ~pin_sync_r)
                                            : (~pin_last_r & pin_sync_r);

  // Source frozen in sleep so neither prescaler nor count moves
  assign source_tick = ~sleep & (option_cfg.external_source ? pin_edge : cycle_tick);

  // Dedicated prescaler; the watchdog keeps its own elsewhere
  timer_zero_prescaler #(
    .WIDTH (PRESCALE_W)
  ) u_prescaler (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (source_tick & ~option_cfg.prescaler_bypass),
    .clear   (count_write),
    .select  (option_cfg.prescale_select),
    .divided (presc_out)
  );

  // Prescaler output sampled on Q2 then Q4; a rise across them is one count
  // Cleared with the prescaler, else a rise caught before a write counts after it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      presc_s2_r <= 1'b0;
      presc_s4_r <= 1'b0;
    end else if (count_write) begin
      presc_s2_r <= 1'b0;
      presc_s4_r <= 1'b0;
    end else begin
      if (phase_r == PHASE_Q2) begin
        presc_s2_r <= presc_out;
      end
      if (phase_r == PHASE_Q4) begin
        presc_s4_r <= presc_s2_r;
      end
    end
  end

  assign presc_rise = (phase_r == PHASE_Q4) & presc_s2_r & ~presc_s4_r;

  // Bypass gives one count per source tick
  assign count_inc = ~sleep & (option_cfg.prescaler_bypass ? source_tick : presc_rise);

  assign rollover  = count_inc & ~count_write & (count_r == COUNT_MAX);
  assign count_nxt = count_r + COUNT_W'(1);

  // Software write takes precedence over an increment in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_r <= COUNT_RESET;
    end else if (count_write) begin
      count_r <= count_wdata;
    end else if (count_inc) begin
      count_r <= count_nxt;
    end
  end

  // Set beats a simultaneous software clear so no overflow is lost
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else if (rollover) begin
      flag_r <= 1'b1;
    end else if (control_write) begin
      flag_r <= control_wdata.overflow_flag;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      enable_r <= 1'b0;
    end else if (control_write) begin
      enable_r <= control_wdata.overflow_irq_enable;
    end
  end

  // Request follows the sticky flag gated by the enable
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= flag_r & enable_r;
    end
  end

  assign timer_count                               = count_r;
  assign interrupt_control_reg.overflow_flag       = flag_r;
  assign interrupt_control_reg.overflow_irq_enable = enable_r;
  assign overflow_irq                              = irq_r;
  // Nothing advances in sleep, so this block never asks for wake-up
  assign wake_request                              = 1'b0;

endmodule : timer_zero_prescaled_counter

`default_nettype wire

// File: tb/timer_zero_properties.sv
`timescale 1ns/100ps
`default_nettype none
module timer_zero_properties import timer_zero_pkg::*; (
  input wire logic               clock,
  input wire logic               reset_n,
  input wire logic               sleep,
  input wire logic               external_count_input,
  input wire option_cfg_s        option_cfg,
  input wire logic               count_write,
  input wire logic [7:0]         count_wdata,
  input wire logic               control_write,
  input wire interrupt_control_s control_wdata,
  input wire logic [7:0]         timer_count,
  input wire interrupt_control_s interrupt_control_reg,
  input wire logic               overflow_irq,
  input wire logic               wake_request
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  sequence incr;
    timer_count == $past(timer_count) + 8'h01 && !$past(count_write);
  endsequence
  sequence quiet;
    !option_cfg.external_source && option_cfg.prescaler_bypass && !sleep && !count_write;
  endsequence
  AST_WAKE: assert property (!wake_request) else $error("wake raised");
  AST_LOAD: assert property (count_write |=> timer_count == $past(count_wdata))
    else $error("count load lost");
  AST_FREEZE: assert property (sleep && !count_write |=> $stable(timer_count))
    else $error("count moved in sleep");
  AST_SET: assert property ($past(timer_count) == 8'hFF && timer_count == 8'h00
    && !$past(count_write) |-> interrupt_control_reg.overflow_flag) else $error("flag not set");
  AST_HOLD: assert property (interrupt_control_reg.overflow_flag && !control_write
    |=> interrupt_control_reg.overflow_flag) else $error("flag dropped");
  AST_CLEAR: assert property (control_write && !control_wdata.overflow_flag
    && timer_count != 8'hFF |=> !interrupt_control_reg.overflow_flag) else $error("no clear");
  AST_IRQ: assert property (1'b1 |=> overflow_irq == $past(interrupt_control_reg.overflow_flag
    && interrupt_control_reg.overflow_irq_enable)) else $error("irq wrong");
  AST_UNITY: assert property (incr ##0 quiet ##1 quiet[*4]
    |-> $past(timer_count) == $past(timer_count, 4) ##0 incr) else $error("rate wrong");
endmodule : timer_zero_properties
`default_nettype wire

// File: tb/ext_clock_source.sv
`timescale 1ns/100ps
`default_nettype none
module ext_clock_source (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [7:0] half,
  output var logic        pin
);
  logic [7:0] cnt_r;
  // Rests low between bursts so no stray edge is counted
  always_ff @(posedge clock) begin
    if (!run) begin
      cnt_r <= 8'h00;
      pin   <= 1'b0;
    end else if (cnt_r == half - 8'h01) begin
      cnt_r <= 8'h00;
      pin   <= ~pin;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule : ext_clock_source
`default_nettype wire

// File: tb/test_timer_zero_prescaled_counter.sv
`timescale 1ns/100ps
`default_nettype none
module test_timer_zero_prescaled_counter import timer_zero_pkg::*;;
  logic clock = 1'b0, reset_n = 1'b0, sleep = 1'b0, run = 1'b0, pin, irq, wake;
  logic count_write = 1'b0, control_write = 1'b0;
  logic [7:0] count_wdata = 8'h00, timer_count;
  option_cfg_s cfg = 6'h0F;
  interrupt_control_s cw = 2'h0, ictl;
  int mismatches = 0, n_tests = 0;
  always #25 clock = ~clock;
  ext_clock_source src (.clock(clock), .run(run), .half(8'h08), .pin(pin));
  timer_zero_prescaled_counter dut (.clock(clock), .reset_n(reset_n), .sleep(sleep),
    .external_count_input(pin), .option_cfg(cfg), .count_write(count_write),
    .count_wdata(count_wdata), .control_write(control_write), .control_wdata(cw),
    .timer_count(timer_count), .interrupt_control_reg(ictl), .overflow_irq(irq),
    .wake_request(wake));
  // Outputs are read at the edge, so each read shows the state of the edge before
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask : step
  task automatic wr(input logic [7:0] v);
    count_write <= 1'b1;
    count_wdata <= v;
    @(posedge clock);
    count_write <= 1'b0;
  endtask : wr
  task automatic ctl(input interrupt_control_s v);
    control_write <= 1'b1;
    cw            <= v;
    @(posedge clock);
    control_write <= 1'b0;
  endtask : ctl
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic t_rates();
    cfg <= 6'h08;
    wr(8'hF0);
    step(1);
    check("load", 8'hF0, timer_count);
    step(40);
    check("bypass", 8'hFA, timer_count);
    for (int s = 0; s < 8; s++) begin
      cfg <= {3'b000, 3'(s)};
      wr(8'h00);
      step(20 << s);
      check("prescaled", 8'h02, timer_count);
    end
    $display("test rates done");
  endtask : t_rates
  task automatic t_sleep();
    cfg   <= 6'h08;
    sleep <= 1'b1;
    wr(8'h55);
    step(41);
    check("frozen", 8'h55, timer_count);
    check("wake", 8'h00, {7'h00, wake});
    sleep <= 1'b0;
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_ovf();
    ctl(2'b00);
    wr(8'hFE);
    step(13);
    check("wrap", 8'h01, timer_count);
    check("ctl", 8'h02, {6'h00, ictl});
    check("irq", 8'h00, {7'h00, irq});
    ctl(2'b11);
    step(2);
    check("irq", 8'h01, {7'h00, irq});
    ctl(2'b01);
    step(2);
    check("ctl", 8'h01, {6'h00, ictl});
    check("irq", 8'h00, {7'h00, irq});
    $display("test overflow done");
  endtask : t_ovf
  task automatic t_ext();
    for (int b = 0; b < 3; b++) begin
      cfg <= {1'b1, 1'(b == 2), 1'(b != 0), 3'h0};
      wr(8'h00);
      run <= 1'b1;
      step(160);
      run <= 1'b0;
      step(20);
      check("external", b ? 8'h0A : 8'h05, timer_count);
    end
    $display("test external done");
  endtask : t_ext
  initial begin
    step(10);
    reset_n <= 1'b1;
    step(1);
    t_rates();
    t_sleep();
    t_ovf();
    t_ext();
    end_of_test();
  end
  initial begin
    step(20000);
    mismatches++;
    end_of_test();
  end
endmodule : test_timer_zero_prescaled_counter
bind timer_zero_prescaled_counter timer_zero_properties chk (.clock(clock), .reset_n(reset_n),
  .sleep(sleep), .external_count_input(external_count_input), .option_cfg(option_cfg),
  .count_write(count_write), .count_wdata(count_wdata), .control_write(control_write),
  .control_wdata(control_wdata), .timer_count(timer_count), .overflow_irq(overflow_irq),
  .interrupt_control_reg(interrupt_control_reg), .wake_request(wake_request));
`default_nettype wire
